/* verilog/pdm_top.sv */
/*
 * Program store, table read engine, two-bank data space and the shared
 * programming/debug pin pair, with registers on an AXI4-Lite slave.
 * Assumes one clock, programming pins arriving asynchronously, and that
 * the programmer drives the clock pin and leaves the pins otherwise free.
 */
`timescale 1ns/1ps
`include "pdm_cfg.svh"

module pdm_top import pdm_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire pdm_axi_req_t axi_req, // AXI4-Lite master to slave
  output pdm_axi_rsp_t axi_rsp, // AXI4-Lite slave to master
  input wire logic prog_mode, // In-circuit programming active
  input wire logic debug_mode, // On-chip debug active
  input wire logic [1:0] func_out, // Normal pin functions, bit0/bit2
  input wire logic [1:0] func_oe, // Normal pin enables, bit0/bit2
  input wire logic dbg_data_out, // Debug engine data to pin
  input wire logic dbg_data_oe, // Debug engine data enable
  input wire logic port_a_bit_zero_in, // Data pin level
  input wire logic port_a_bit_two_in, // Clock pin level
  output logic port_a_bit_zero_out, // Data pin drive value
  output logic port_a_bit_zero_oe, // Data pin enable
  output logic port_a_bit_two_out, // Clock pin drive value
  output logic port_a_bit_two_oe, // Clock pin enable
  output logic debug_serial_data, // Synced data pin to debug engine
  output logic debug_serial_clock // Synced clock pin to debug engine
);

  pdm_st_t s;
  pdm_st_t next_s;
  logic tick;
  logic is_tbl;
  logic is_gp;
  logic cur_bank;
  logic [7:0] cur_val;
  logic [7:0] bit_mask;
  logic wr_en;
  logic [7:0] wr_val;
  logic wr_bank;
  logic ser_rise;
  logic [4:0] scnt_inc;
  logic [27:0] ssh_new;
  logic ser_re;
  logic pm_we;
  logic pm_re;
  logic [`PDM_PM_AW-1:0] pm_raddr;
  logic [`PDM_PM_AW-1:0] tbl_addr;
  logic [`PDM_PM_WIDTH-1:0] pm_rdata;
  logic dm_we;
  logic dm_re;
  logic [7:0] dm_rdata;

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // Unmapped and bank-restricted addresses fall through to zero
  function automatic logic [7:0] sfr_read(input pdm_st_t q,
      input logic [7:0] a, input logic bk);
    logic [7:0] r;
    r = `PDM_RST_BYTE;
    if (a == `PDM_SFR_BP) begin
      r = {7'h00, q.bank};
    end else if (a == `PDM_SFR_PCL) begin
      r = q.pc[7:0];
    end else if (a == `PDM_SFR_TBLP) begin
      r = q.tblp;
    end else if (a == `PDM_SFR_TABLE_HIGH_BYTE) begin
      r = q.table_high_byte;
    end else if (a == `PDM_SFR_EEC && bk) begin
      r = q.eec;
    end
    return r;
  endfunction : sfr_read

  // ************************************************************
  // Memories
  // ************************************************************
  pdm_mem #(.DEPTH(`PDM_PM_DEPTH), .WIDTH(`PDM_PM_WIDTH),
    .AW(`PDM_PM_AW)) u_prog (
    .clk_sys(clk_sys),
    .we(pm_we),
    .waddr(ssh_new[26:16]),
    .wdata(ssh_new[15:0]),
    .re(pm_re),
    .raddr(pm_raddr),
    .rdata(pm_rdata)
  );

  pdm_mem #(.DEPTH(`PDM_DM_DEPTH), .WIDTH(8), .AW(`PDM_DM_AW)) u_data (
    .clk_sys(clk_sys),
    .we(dm_we),
    .waddr(s.cmd.addr[6:0]),
    .wdata(wr_val),
    .re(dm_re),
    .raddr(s.cmd.addr[6:0]),
    .rdata(dm_rdata)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s = s;
    tick = (s.tcnt == `PDM_TCYC_W'(`PDM_TCYC_CLKS - 1));
    next_s.tcnt = s.tcnt + `PDM_TCYC_W'(1);
    is_tbl = (s.cmd.op == PDM_OP_TRD_CUR) || (s.cmd.op == PDM_OP_TRD_LAST);
    is_gp = (s.cmd.addr >= `PDM_GP_BASE);
    cur_bank = s.cmd.indirect ? s.bank : 1'b0;
    bit_mask = 8'h01 << s.cmd.bitsel;
    // Bank 1 has no storage bytes, so those read as zero
    cur_val = is_gp ? (cur_bank ? 8'h00 : dm_rdata)
                    : sfr_read(s, s.cmd.addr, cur_bank);
    // Table pointer and page only; the PC itself is never stepped here
    tbl_addr = (s.cmd.op == PDM_OP_TRD_LAST)
             ? (`PDM_LAST_PAGE | {3'h0, s.tblp})
             : {s.pc[10:8], s.tblp};
    dm_re = (s.st == PDM_EXEC1) && !is_tbl;
    wr_en = 1'b0;
    wr_val = s.cmd.wdata;
    wr_bank = cur_bank;

    // Engine: table reads finish at the second tick, data ops at the first
    unique case (s.st)
      PDM_IDLE: begin
      end
      PDM_WAIT: begin
        if (tick) begin
          next_s.st = PDM_EXEC1;
        end
      end
      PDM_EXEC1: begin
        if (tick) begin
          next_s.st = is_tbl ? PDM_EXEC2 : PDM_IDLE;
          unique case (s.cmd.op)
            PDM_OP_DWRITE: begin
              wr_en = 1'b1;
            end
            PDM_OP_DREAD: begin
              next_s.result = cur_val;
            end
            PDM_OP_BSET: begin
              wr_en = 1'b1;
              wr_val = cur_val | bit_mask;
            end
            PDM_OP_BCLR: begin
              wr_en = 1'b1;
              wr_val = cur_val & ~bit_mask;
            end
            default: begin
            end
          endcase
        end
      end
      PDM_EXEC2: begin
        if (tick) begin
          next_s.st = PDM_IDLE;
          wr_en = 1'b1;
          wr_val = pm_rdata[7:0];
          wr_bank = 1'b0;
          next_s.table_high_byte = 8'(pm_rdata >> 8);
        end
      end
    endcase

    // Destination decode; table_high_byte is loaded only by table reads
    dm_we = wr_en && is_gp && !wr_bank;
    if (wr_en && !is_gp) begin
      if (s.cmd.addr == `PDM_SFR_BP) begin
        next_s.bank = wr_val[0];
      end else if (s.cmd.addr == `PDM_SFR_PCL) begin
        next_s.pc[7:0] = wr_val;
      end else if (s.cmd.addr == `PDM_SFR_TBLP) begin
        next_s.tblp = wr_val;
      end else if (s.cmd.addr == `PDM_SFR_EEC && wr_bank) begin
        next_s.eec = wr_val;
      end
    end

    // AXI write: address and data are taken independently
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = `PDM_RESP_OKAY;
      unique case (s.awaddr)
        `PDM_REG_CMD: begin
          // Commands during a busy engine or programming are dropped
          if (s.st == PDM_IDLE && !prog_mode) begin
            next_s.cmd = pdm_cmd_t'(apply_strb(s.cmd, s.wdata, s.wstrb));
            next_s.st = PDM_WAIT;
          end
        end
        `PDM_REG_TBLP: begin
          if (s.wstrb[0]) begin
            next_s.tblp = s.wdata[7:0];
          end
        end
        `PDM_REG_BANK: begin
          if (s.wstrb[0]) begin
            next_s.bank = s.wdata[0];
          end
        end
        `PDM_REG_PC: begin
          if (s.st == PDM_IDLE) begin
            next_s.pc = 11'(apply_strb({21'h0, s.pc}, s.wdata, s.wstrb));
          end
        end
        `PDM_REG_STATUS, `PDM_REG_TABLE_HIGH_BYTE, `PDM_REG_RESULT,
        `PDM_REG_EEC: begin
        end
        default: begin
          next_s.rsp.bresp = `PDM_RESP_SLVERR;
        end
      endcase
    end

    // AXI read
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = `PDM_RESP_OKAY;
      next_s.rsp.rdata = `PDM_RST_WORD;
      unique case (axi_req.araddr)
        `PDM_REG_CMD: next_s.rsp.rdata = s.cmd;
        `PDM_REG_STATUS: begin
          next_s.rsp.rdata[`PDM_STAT_BUSY] = (s.st != PDM_IDLE);
          next_s.rsp.rdata[`PDM_STAT_PROG] = prog_mode;
          next_s.rsp.rdata[`PDM_STAT_DEBUG] = debug_mode;
          next_s.rsp.rdata[`PDM_STAT_PC_LSB +: `PDM_PM_AW] = s.pc;
        end
        `PDM_REG_TBLP: next_s.rsp.rdata[7:0] = s.tblp;
        `PDM_REG_TABLE_HIGH_BYTE: next_s.rsp.rdata[7:0] = s.table_high_byte;
        `PDM_REG_BANK: next_s.rsp.rdata[0] = s.bank;
        `PDM_REG_RESULT: next_s.rsp.rdata[7:0] = s.result;
        `PDM_REG_PC: next_s.rsp.rdata[`PDM_PM_AW-1:0] = s.pc;
        `PDM_REG_EEC: next_s.rsp.rdata[7:0] = s.eec;
        default: next_s.rsp.rresp = `PDM_RESP_SLVERR;
      endcase
    end
    next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.w_got && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;

    // ************************************************************
    // Serial programming on the shared data and clock pins
    // ************************************************************
    next_s.ck_sy = {s.ck_sy[1:0], port_a_bit_two_in};
    next_s.da_sy = {s.da_sy[0], port_a_bit_zero_in};
    ser_rise = s.ck_sy[1] && !s.ck_sy[2];
    scnt_inc = s.scnt + 5'h01;
    ssh_new = {s.ssh[26:0], s.da_sy[1]};
    ser_re = 1'b0;
    pm_we = 1'b0;
    next_s.sload = 1'b0;
    if (s.sload) begin
      next_s.sout = pm_rdata;
    end
    if (!prog_mode) begin
      next_s.scnt = 5'h00;
      next_s.srd = 1'b0;
    end else if (ser_rise) begin
      next_s.scnt = scnt_inc;
      if (s.srd) begin
        next_s.sout = {s.sout[14:0], 1'b0};
        if (scnt_inc == 5'(`PDM_SER_FRAME_BITS)) begin
          next_s.scnt = 5'h00;
          next_s.srd = 1'b0;
        end
      end else begin
        next_s.ssh = ssh_new;
        if (scnt_inc == 5'(`PDM_SER_HDR_BITS) && ssh_new[11]) begin
          ser_re = 1'b1;
          next_s.srd = 1'b1;
          next_s.sload = 1'b1;
        end
        if (scnt_inc == 5'(`PDM_SER_FRAME_BITS)) begin
          pm_we = 1'b1;
          next_s.scnt = 5'h00;
        end
      end
    end
    // Programming owns the read port; an engine read then sees the programmer's word
    pm_re = ser_re || ((s.st == PDM_EXEC1) && is_tbl);
    pm_raddr = ser_re ? ssh_new[10:0] : tbl_addr;

    // Pin ownership: programming, then debug, then normal functions
    if (prog_mode) begin
      next_s.pa0_out = next_s.sout[15];
      next_s.pa0_oe = next_s.srd;
      next_s.pa2_out = 1'b0;
      next_s.pa2_oe = 1'b0;
    end else if (debug_mode) begin
      next_s.pa0_out = dbg_data_out;
      next_s.pa0_oe = dbg_data_oe;
      next_s.pa2_out = 1'b0;
      next_s.pa2_oe = 1'b0;
    end else begin
      next_s.pa0_out = func_out[0];
      next_s.pa0_oe = func_oe[0];
      next_s.pa2_out = func_out[1];
      next_s.pa2_oe = func_oe[1];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= PDM_IDLE;
      s.pc <= `PDM_RESET_VEC;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign port_a_bit_zero_out = s.pa0_out;
  assign port_a_bit_zero_oe = s.pa0_oe;
  assign port_a_bit_two_out = s.pa2_out;
  assign port_a_bit_two_oe = s.pa2_oe;
  assign debug_serial_data = s.da_sy[1];
  assign debug_serial_clock = s.ck_sy[1];

  // ************************************************************
  // Checks
  // ************************************************************
  sequence tbl_exec_seq;
    (s.st == PDM_EXEC1)[*4] ##1 (s.st == PDM_EXEC2)[*4]
      ##1 (s.st == PDM_IDLE);
  endsequence

  chk_pc_reset_vec: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> s.pc == `PDM_RESET_VEC)
    else $error("pc not at reset vector");
  chk_tbl_two_cyc: assert property (@(posedge clk_sys)
    disable iff (!rst_n) ($rose(s.st == PDM_EXEC1) && is_tbl)
    |-> tbl_exec_seq) else $error("table read not two cycles");
  chk_table_high_byte_only_tbl: assert property (@(posedge clk_sys)
    disable iff (!rst_n) $changed(s.table_high_byte)
    |-> $past(s.st == PDM_EXEC2 && tick))
    else $error("table_high_byte changed outside table read");
  chk_table_high_byte_upper: assert property (@(posedge clk_sys)
    disable iff (!rst_n) (s.st == PDM_EXEC2 && tick)
    |=> s.table_high_byte == $past(pm_rdata[15:8])) else $error("table_high_byte wrong");
  chk_tbl_low_dest: assert property (@(posedge clk_sys)
    disable iff (!rst_n) (s.st == PDM_EXEC2 && tick && is_gp)
    |-> dm_we && wr_val == pm_rdata[7:0]) else $error("low byte lost");
  chk_last_page: assert property (@(posedge clk_sys)
    disable iff (!rst_n) (pm_re && !ser_re
    && s.cmd.op == PDM_OP_TRD_LAST)
    |-> pm_raddr == {3'h7, s.tblp}) else $error("last page address");
  chk_cur_page: assert property (@(posedge clk_sys)
    disable iff (!rst_n) (pm_re && !ser_re
    && s.cmd.op == PDM_OP_TRD_CUR)
    |-> pm_raddr == {s.pc[10:8], s.tblp}) else $error("page address");
  chk_direct_bank0: assert property (@(posedge clk_sys)
    disable iff (!rst_n) (wr_en && is_gp && !s.cmd.indirect
    && s.cmd.op == PDM_OP_DWRITE) |-> dm_we)
    else $error("direct write missed bank 0");
  chk_eec_bank1: assert property (@(posedge clk_sys)
    disable iff (!rst_n) $changed(s.eec) |-> $past(wr_bank && wr_en))
    else $error("eec written outside bank 1");
  chk_bit_keep: assert property (@(posedge clk_sys)
    disable iff (!rst_n) (dm_we && s.cmd.op == PDM_OP_BSET)
    |-> ((wr_val ^ dm_rdata) & ~bit_mask) == 8'h00
    && wr_val[s.cmd.bitsel]) else $error("bit set disturbed byte");
  chk_clk_pin_in: assert property (@(posedge clk_sys)
    disable iff (!rst_n) $past(prog_mode || debug_mode)
    |-> !port_a_bit_two_oe) else $error("clock pin driven");

endmodule : pdm_top

/* verilog/pdm_cfg.svh */
/*
 * Constants of the program/data memory map block: register offsets,
 * status bits, data-space addresses, reset values and cycle counts.
 * Assumes it is included by its bare name before the package and modules.
 */
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH

// ************************************************************
// Memory geometry
// ************************************************************
`define PDM_PM_DEPTH 2048
`define PDM_PM_WIDTH 16
`define PDM_PM_AW 11
`define PDM_DM_DEPTH 128
`define PDM_DM_AW 7
`define PDM_RESET_VEC 11'h000
`define PDM_LAST_PAGE 11'h700
`define PDM_GP_BASE 8'h80

// ************************************************************
// Special function addresses in data space
// ************************************************************
`define PDM_SFR_BP 8'h04
`define PDM_SFR_PCL 8'h06
`define PDM_SFR_TBLP 8'h07
`define PDM_SFR_TABLE_HIGH_BYTE 8'h08
`define PDM_SFR_EEC 8'h40

// ************************************************************
// Bus register byte offsets
// ************************************************************
`define PDM_REG_CMD 8'h00
`define PDM_REG_STATUS 8'h04
`define PDM_REG_TBLP 8'h08
`define PDM_REG_TABLE_HIGH_BYTE 8'h0c
`define PDM_REG_BANK 8'h10
`define PDM_REG_RESULT 8'h14
`define PDM_REG_PC 8'h18
`define PDM_REG_EEC 8'h1c
`define PDM_STAT_BUSY 0
`define PDM_STAT_PROG 1
`define PDM_STAT_DEBUG 2
`define PDM_STAT_PC_LSB 16
`define PDM_RESP_OKAY 2'h0
`define PDM_RESP_SLVERR 2'h2

// ************************************************************
// Reset values and timing
// ************************************************************
`define PDM_RST_BYTE 8'h00
`define PDM_RST_WORD 32'h0000_0000
`define PDM_TCYC_CLKS 4
`define PDM_TCYC_W 2
`define PDM_SER_HDR_BITS 12
`define PDM_SER_FRAME_BITS 28

`endif

/* verilog/pdm_pkg.sv */
/*
 * Types of the program/data memory map block: states, command layout,
 * bus carriers and the block's state record.
 * Assumes pdm_cfg.svh is available on the include path.
 */
`include "pdm_cfg.svh"

package pdm_pkg;

  typedef enum logic [3:0] {
    PDM_IDLE  = 4'b0001,
    PDM_WAIT  = 4'b0010,
    PDM_EXEC1 = 4'b0100,
    PDM_EXEC2 = 4'b1000
  } pdm_state_t;

  typedef enum logic [2:0] {
    PDM_OP_NONE = 3'h0,
    PDM_OP_TRD_CUR = 3'h1,
    PDM_OP_TRD_LAST = 3'h2,
    PDM_OP_DWRITE = 3'h3,
    PDM_OP_DREAD = 3'h4,
    PDM_OP_BSET = 3'h5,
    PDM_OP_BCLR = 3'h6,
    PDM_OP_SPARE = 3'h7
  } pdm_op_t;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] wdata;
    logic [7:0] addr;
    logic rsvd_lo;
    logic [2:0] bitsel;
    logic indirect;
    pdm_op_t op;
  } pdm_cmd_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pdm_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pdm_axi_rsp_t;

  typedef struct packed {
    pdm_state_t st;
    logic [`PDM_TCYC_W-1:0] tcnt;
    pdm_cmd_t cmd;
    logic [`PDM_PM_AW-1:0] pc;
    logic [7:0] tblp;
    logic [7:0] table_high_byte;
    logic [7:0] eec;
    logic [7:0] result;
    logic bank;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    pdm_axi_rsp_t rsp;
    logic [2:0] ck_sy;
    logic [1:0] da_sy;
    logic [4:0] scnt;
    logic [27:0] ssh;
    logic srd;
    logic sload;
    logic [15:0] sout;
    logic pa0_out;
    logic pa0_oe;
    logic pa2_out;
    logic pa2_oe;
  } pdm_st_t;

endpackage : pdm_pkg

/* verilog/pdm_mem.sv */
/*
 * Simple two-port synchronous memory: one write port, one read port with
 * registered read data that holds while no read is requested.
 * Assumes a single clock; contents are not reset.
 */
`timescale 1ns/1ps
`include "pdm_cfg.svh"

module pdm_mem import pdm_pkg::*; #(
  parameter int DEPTH = `PDM_PM_DEPTH,
  parameter int WIDTH = `PDM_PM_WIDTH,
  parameter int AW = `PDM_PM_AW
) (
  input wire logic clk_sys, // System clock
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [WIDTH-1:0] wdata, // Write data
  input wire logic re, // Read strobe
  input wire logic [AW-1:0] raddr, // Read address
  output logic [WIDTH-1:0] rdata // Registered read data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : pdm_mem

/* dv/pdm_prog_model.sv */
/*
 * Serial programmer model: sends write and read frames on the data/clock
 * pin pair and collects the word that a read frame returns.
 * Assumes the bench raises prog_mode around each frame.
 */
`timescale 1ns/1ps

module pdm_prog_model (
  input wire logic clk_sys, // Bench clock, paces the link
  input wire logic da_in, // Data pin level on the board
  output logic ck, // Programming clock pin drive
  output logic da, // Programming data pin drive
  output logic da_oe // Data pin enable
);
  initial begin
    ck = 1'b0;
    da = 1'b0;
    da_oe = 1'b0;
  end

  // Clock stands low between frames; 9 clk low, 8 clk high per bit, msb first
  // Read frame: pin let go 2 clk after the 12th rise, before the device
  // turns it round; each word bit is taken just before the next rise
  task automatic send(input logic [27:0] f,
      output logic [15:0] q);
    q = 16'h0000;
    for (int i = 27; i >= 0; i--) begin
      @(posedge clk_sys);
      da <= f[i];
      da_oe <= !(f[27] && i < 16);
      repeat (8) @(posedge clk_sys);
      if (i < 16) begin
        q[i] = da_in;
      end
      ck <= 1'b1;
      repeat (2) @(posedge clk_sys);
      if (f[27] && i == 16) begin
        da_oe <= 1'b0;
      end
      repeat (6) @(posedge clk_sys);
      ck <= 1'b0;
    end
    @(posedge clk_sys);
    da_oe <= 1'b0;
  endtask : send
endmodule : pdm_prog_model

/* dv/pdm_top_tb.sv */
/*
 * Self-checking bench for pdm_top: AXI4-Lite master, programmer model.
 * Assumes the design files compile ahead of this one.
 */
`timescale 1ns/1ps

module pdm_top_tb import pdm_pkg::*;;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] ex;
  } pdm_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic prog_mode = 1'b0, debug_mode = 1'b0, dbg_o = 1'b0, dbg_oe = 1'b0;
  logic [1:0] func_out = 2'h0, func_oe = 2'h0;
  logic z_out, z_oe, t_out, t_oe, pm_ck, pm_da, pm_oe, dsd, dsc;
  logic [1:0] r;
  logic [31:0] d;
  logic [15:0] q;
  pdm_axi_req_t req = '0;
  pdm_axi_rsp_t rsp;
  pdm_row_t rows [23];
  int fail_count = 0, n_compared = 0, cyc = 0;
  // Wire level: device enable wins, else the programmer's drive;
  // an undriven data pin shows the inverse of the programmer's da value
  wire pin0 = z_oe ? z_out : (pm_oe ? pm_da : ~pm_da);
  wire pin2 = t_oe ? t_out : pm_ck;

  pdm_top pdm_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .axi_req(req),
    .axi_rsp(rsp), .prog_mode(prog_mode), .debug_mode(debug_mode),
    .func_out(func_out), .func_oe(func_oe), .dbg_data_out(dbg_o),
    .dbg_data_oe(dbg_oe), .port_a_bit_zero_in(pin0),
    .port_a_bit_two_in(pin2), .port_a_bit_zero_out(z_out),
    .port_a_bit_zero_oe(z_oe), .port_a_bit_two_out(t_out),
    .port_a_bit_two_oe(t_oe), .debug_serial_data(dsd),
    .debug_serial_clock(dsc));
  pdm_prog_model pdm_prog_model_i (.clk_sys(clk_sys), .da_in(pin0),
    .ck(pm_ck), .da(pm_da), .da_oe(pm_oe));

  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_idle();
    do axi_rd(8'h04); while (d[0] !== 1'b0);
  endtask : wait_idle

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    rows = '{'{8'h08, 32'h6, 8'h08, 32'h6}, '{8'h00, 32'h8102, 8'h0c, 32'hc3},
      '{8'h00, 32'h8104, 8'h14, 32'h5a}, '{8'h00, 32'ha58003, 8'h04, 32'h0},
      '{8'h00, 32'h8015, 8'h0c, 32'hc3}, '{8'h00, 32'h8004, 8'h14, 32'ha7},
      '{8'h00, 32'h8076, 8'h0c, 32'hc3}, '{8'h00, 32'h8004, 8'h14, 32'h27},
      '{8'h18, 32'h306, 8'h04, 32'h3060000}, '{8'h08, 32'h10, 8'h08, 32'h10},
      '{8'h00, 32'h8201, 8'h0c, 32'h7e}, '{8'h00, 32'h8204, 8'h14, 32'h81},
      '{8'h10, 32'h1, 8'h10, 32'h1}, '{8'h00, 32'h3c400b, 8'h1c, 32'h3c},
      '{8'h00, 32'h554003, 8'h1c, 32'h3c}, '{8'h00, 32'h11800b, 8'h1c, 32'h3c},
      '{8'h00, 32'h800c, 8'h14, 32'h0}, '{8'h00, 32'h8004, 8'h14, 32'h27},
      '{8'h00, 32'h993003, 8'h0c, 32'h7e}, '{8'h00, 32'h3004, 8'h14, 32'h0},
      '{8'h00, 32'h990803, 8'h0c, 32'h7e}, '{8'h0c, 32'hff, 8'h0c, 32'h7e},
      '{8'h00, 32'h404, 8'h14, 32'h1}};
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(8'h18);
    check(d, 32'h0);
    prog_mode <= 1'b1;
    pdm_prog_model_i.send({1'b0, 11'h706, 16'hc35a}, q);
    pdm_prog_model_i.send({1'b0, 11'h310, 16'h7e81}, q);
    pdm_prog_model_i.send({1'b1, 11'h706, 16'h0000}, q);
    check({16'h0000, q}, 32'hc35a);
    repeat (8) @(posedge clk_sys);
    prog_mode <= 1'b0;
    foreach (rows[i]) begin
      axi_wr(rows[i].wa, rows[i].wd);
      wait_idle();
      axi_rd(rows[i].ra);
      check(d, rows[i].ex);
    end
    // ************************************************************
    // Unmapped address, mid-run reset, pin muxing
    // ************************************************************
    axi_wr(8'h20, 32'h1);
    check({30'h0, r}, 32'h2);
    axi_rd(8'h20);
    check({30'h0, r}, 32'h2);
    check(d, 32'h0);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(8'h04);
    check(d, 32'h0);
    axi_rd(8'h10);
    check(d, 32'h0);
    axi_rd(8'h0c);
    check(d, 32'h0);
    func_oe <= 2'h3;
    func_out <= 2'h1;
    repeat (3) @(posedge clk_sys);
    check({t_oe, t_out, z_oe, z_out}, 4'hb);
    debug_mode <= 1'b1;
    dbg_oe <= 1'b1;
    dbg_o <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({t_oe, z_oe, z_out}, 3'h3);
    repeat (3) @(posedge clk_sys);
    check({dsc, dsd}, 2'h1);
    prog_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({t_oe, z_oe}, 2'h0);
    complete_run();
  end
endmodule : pdm_top_tb
